// File: include/dpc_pkg.sv
// package: offsets, field positions and reset values for the data path control block
`default_nettype none
package dpc_pkg;
    localparam logic [7:0] DPC_ADDR_ERROR   = 8'h92;
    localparam logic [7:0] DPC_ADDR_CONTROL = 8'h93;
    localparam logic [7:0] DPC_ADDR_STATUS  = 8'h94;
    localparam int DPC_ERR_PCI   = 6;
    localparam int DPC_ERR_MPAR  = 5;
    localparam int DPC_ERR_DPAR  = 4;
    localparam int DPC_ERR_SQPAR = 3;
    localparam int DPC_ERR_ILL   = 2;
    localparam int DPC_CTL_WIDE  = 6;
    localparam int DPC_CTL_SCSI  = 5;
    localparam int DPC_CTL_SDMA  = 4;
    localparam int DPC_CTL_HDMA  = 3;
    localparam int DPC_CTL_DIR   = 2;
    localparam int DPC_CTL_DRAIN = 1;
    localparam int DPC_CTL_CLEAR = 0;
    localparam int DPC_ST_CACHE  = 6;
    localparam int DPC_ST_QWDEMP = 5;
    localparam int DPC_ST_MREQ   = 4;
    localparam int DPC_ST_HDONE  = 3;
    localparam int DPC_ST_THRSH  = 2;
    localparam int DPC_ST_FULL   = 1;
    localparam int DPC_ST_EMPTY  = 0;
    localparam logic [7:0] DPC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DPC_ERROR_RESET   = 8'h00;
    localparam logic [7:0] DPC_STATUS_RESET  = 8'h21;
    localparam logic [2:0] DPC_OFFSET_RESET  = 3'h0;
endpackage
`default_nettype wire

// File: src/dpc_data_path_control.sv
// data path control and fatal error status block
// Function
// - pci error summary is OR of status
// - memory parity error sets when check enabled
// - datapath parity error sets when check enabled
// - control store parity error unless disabled
// - illegal instruction fetch sets error flag
// - resets force control register to zero
// - wide odd hold keeps final low byte
// - scsi enable gates acks, readback hardware
// - sync data-in stays enabled with offset
// - scsi dma enable gates, readback hardware
// - host dma clear pauses, preserves state
// - direction bit routes buffer data
// - sequencer free access when dma idle
// - direction ack changes only when idle
// - drain request pushes remaining bytes
// - auto drain on count zero, phase
// - sequencer drain accepts partial quad word
// - clear strobe forces buffer empty
// - clear strobe loads byte offset pointers
//
// The implementer's own choice: strobed register access.
`default_nettype none
module dpc_data_path_control
    import dpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       soft_chip_reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] pci_status_bits,
    input  wire logic       memory_parity_fail,
    input  wire logic       memory_parity_check_enable,
    input  wire logic       datapath_parity_fail,
    input  wire logic       datapath_parity_check_enable,
    input  wire logic       control_store_parity_fail,
    input  wire logic       control_store_parity_disable,
    input  wire logic       illegal_fetch,
    input  wire logic       clear_parity_errors,
    input  wire logic       wide_transfer,
    input  wire logic       odd_byte_count,
    input  wire logic       sync_offset_nonzero,
    input  wire logic       data_in_phase,
    input  wire logic       scsi_bus_idle,
    input  wire logic       scsi_dma_idle,
    input  wire logic       host_dma_idle,
    input  wire logic       scsi_count_zero,
    input  wire logic       scsi_phase_change,
    input  wire logic       auto_drain_disable,
    input  wire logic       drain_done,
    input  wire logic       sequencer_writing,
    input  wire logic [2:0] host_address_low_bits,
    input  wire logic [6:0] buffer_status_in,
    output logic            scsi_ack_allowed,
    output logic            scsi_dma_run,
    output logic            host_dma_run,
    output logic            path_to_scsi,
    output logic            sequencer_free_access,
    output logic            hold_odd_byte,
    output logic            drain_active,
    output logic            accept_partial_quad,
    output logic            buffer_clear,
    output logic      [2:0] byte_offset_pointer,
    output logic            error_pause
);
    logic [7:0] control;
    logic [7:0] next_control;
    logic       scsi_ack;
    logic       next_scsi_ack;
    logic       sdma_ack;
    logic       next_sdma_ack;
    logic       hdma_ack;
    logic       next_hdma_ack;

    logic       path_sense_ack;
    logic       next_path_sense_ack;

    logic       drain_pending;
    logic       next_drain_pending;

    logic       clear_pulse;
    logic       next_clear_pulse;

    logic [2:0] offset_ptr;
    logic [2:0] next_offset_ptr;

    logic [5:3] errors;
    logic [5:3] next_errors;

    logic       illegal_err;
    logic       next_illegal_err;

    logic       buf_empty;
    logic       next_buf_empty;
    logic [7:0] next_rdata;
    logic [7:0] status_view;
    logic       wr_ctl;

    logic       next_scsi_ack_allowed;
    logic       next_scsi_dma_run;
    logic       next_host_dma_run;
    logic       next_path_to_scsi;
    logic       next_free_access;
    logic       next_hold_odd_byte;
    logic       next_drain_active;
    logic       next_partial_quad;
    logic       next_buffer_clear;
    logic [2:0] next_offset_out;
    logic       next_error_pause;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // ack stays up until the stage reports idle
    function automatic logic stage_ack(input logic en,
                                       input logic ack,
                                       input logic idle);
        stage_ack = en || (ack && !idle);
    endfunction

    function automatic logic [7:0] error_view(input logic [5:0] pci,
                                              input logic [5:3] errs,
                                              input logic       ill);
        error_view                = DPC_ERROR_RESET;
        error_view[DPC_ERR_PCI]   = |pci;
        error_view[DPC_ERR_MPAR]  = errs[DPC_ERR_MPAR];
        error_view[DPC_ERR_DPAR]  = errs[DPC_ERR_DPAR];
        error_view[DPC_ERR_SQPAR] = errs[DPC_ERR_SQPAR];
        error_view[DPC_ERR_ILL]   = ill;
    endfunction

    assign wr_ctl = reg_write && hit(reg_addr, DPC_ADDR_CONTROL);

    // control register and acknowledges
    always_comb
    begin
        next_control        = control;
        next_scsi_ack       = scsi_ack;
        next_sdma_ack       = sdma_ack;
        next_hdma_ack       = hdma_ack;
        next_path_sense_ack = path_sense_ack;
        next_drain_pending  = drain_pending;
        next_clear_pulse    = 1'b0;
        next_offset_ptr     = offset_ptr;
        next_buf_empty      = buffer_status_in[DPC_ST_EMPTY];

        if (wr_ctl)
        begin
            next_control                = reg_wdata & 8'h7C;
            next_control[DPC_CTL_DRAIN] = 1'b0;
            next_control[DPC_CTL_CLEAR] = 1'b0;
            if (reg_wdata[DPC_CTL_CLEAR])
            begin
                next_clear_pulse = 1'b1;
                next_buf_empty   = 1'b1;
                next_offset_ptr  = host_address_low_bits;
            end
            if (reg_wdata[DPC_CTL_DRAIN] && !buffer_status_in[DPC_ST_EMPTY]
                && (!control[DPC_CTL_DIR] || sequencer_writing))
            begin
                next_drain_pending = 1'b1;
            end
        end

        if (!auto_drain_disable && !control[DPC_CTL_DIR] && !buffer_status_in[DPC_ST_EMPTY]
            && (scsi_count_zero || scsi_phase_change))
        begin
            next_drain_pending = 1'b1;
        end

        if (drain_pending && drain_done)
        begin
            next_drain_pending = 1'b0;
        end

        // acks fall only once the stage has really stopped
        next_scsi_ack = stage_ack(control[DPC_CTL_SCSI], scsi_ack, scsi_bus_idle);
        next_sdma_ack = stage_ack(control[DPC_CTL_SDMA], sdma_ack, scsi_dma_idle);
        next_hdma_ack = stage_ack(control[DPC_CTL_HDMA], hdma_ack, host_dma_idle);

        if (!next_scsi_ack && !next_sdma_ack && !next_hdma_ack
            && !control[DPC_CTL_SCSI] && !control[DPC_CTL_SDMA] && !control[DPC_CTL_HDMA])
        begin
            next_path_sense_ack = control[DPC_CTL_DIR];
        end
        if (soft_chip_reset)
        begin
            next_control        = DPC_CONTROL_RESET;
            next_scsi_ack       = 1'b0;
            next_sdma_ack       = 1'b0;
            next_hdma_ack       = 1'b0;
            next_path_sense_ack = 1'b0;
            next_drain_pending  = 1'b0;
            next_buf_empty      = 1'b1;
            next_offset_ptr     = DPC_OFFSET_RESET;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            control        <= DPC_CONTROL_RESET;
            scsi_ack       <= 1'b0;
            sdma_ack       <= 1'b0;
            hdma_ack       <= 1'b0;
            path_sense_ack <= 1'b0;
            drain_pending  <= 1'b0;
            clear_pulse    <= 1'b0;
            offset_ptr     <= DPC_OFFSET_RESET;
            buf_empty      <= 1'b1;
        end
        else
        begin
            control        <= next_control;
            scsi_ack       <= next_scsi_ack;
            sdma_ack       <= next_sdma_ack;
            hdma_ack       <= next_hdma_ack;
            path_sense_ack <= next_path_sense_ack;
            drain_pending  <= next_drain_pending;
            clear_pulse    <= next_clear_pulse;
            offset_ptr     <= next_offset_ptr;
            buf_empty      <= next_buf_empty;
        end
    end

    // error flags, set wins over clear
    always_comb
    begin
        next_errors      = errors;
        next_illegal_err = illegal_err;
        if (clear_parity_errors)
        begin
            next_errors = 3'h0;
        end

        if (memory_parity_fail && memory_parity_check_enable)
        begin
            next_errors[DPC_ERR_MPAR] = 1'b1;
        end

        if (datapath_parity_fail && datapath_parity_check_enable)
        begin
            next_errors[DPC_ERR_DPAR] = 1'b1;
        end

        if (control_store_parity_fail && !control_store_parity_disable)
        begin
            next_errors[DPC_ERR_SQPAR] = 1'b1;
        end
        if (soft_chip_reset)
        begin
            next_illegal_err = 1'b0;
        end

        if (illegal_fetch)
        begin
            next_illegal_err = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            errors      <= 3'h0;
            illegal_err <= 1'b0;
        end
        else
        begin
            errors      <= next_errors;
            illegal_err <= next_illegal_err;
        end
    end

    // buffer status view
    always_comb
    begin
        status_view               = {1'b0, buffer_status_in};
        status_view[DPC_ST_EMPTY] = buf_empty;
        if (clear_pulse)
        begin
            status_view[DPC_ST_EMPTY]  = 1'b1;
            status_view[DPC_ST_QWDEMP] = 1'b1;
            status_view[DPC_ST_FULL]   = 1'b0;
        end
    end

    // register read
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_read)
        begin
            if (hit(reg_addr, DPC_ADDR_ERROR))
            begin
                next_rdata = error_view(pci_status_bits, errors, illegal_err);
            end
            else if (hit(reg_addr, DPC_ADDR_CONTROL))
            begin
                next_rdata[DPC_CTL_WIDE]  = control[DPC_CTL_WIDE];
                next_rdata[DPC_CTL_SCSI]  = scsi_ack;
                next_rdata[DPC_CTL_SDMA]  = sdma_ack;
                next_rdata[DPC_CTL_HDMA]  = hdma_ack;
                next_rdata[DPC_CTL_DIR]   = path_sense_ack;
                next_rdata[DPC_CTL_DRAIN] = drain_pending;
            end
            else if (hit(reg_addr, DPC_ADDR_STATUS))
            begin
                next_rdata = status_view;
            end
        end
    end

    // output next values
    always_comb
    begin
        next_scsi_ack_allowed = next_control[DPC_CTL_SCSI]
                                || (sync_offset_nonzero && data_in_phase);
        next_scsi_dma_run     = next_control[DPC_CTL_SDMA];
        next_host_dma_run     = next_control[DPC_CTL_HDMA];
        next_path_to_scsi     = next_path_sense_ack;
        next_free_access      = !next_sdma_ack && !next_hdma_ack;
        next_hold_odd_byte    = next_control[DPC_CTL_WIDE] && wide_transfer && odd_byte_count;
        next_drain_active     = next_drain_pending;
        next_partial_quad     = next_drain_pending && sequencer_writing;
        next_buffer_clear     = next_clear_pulse;
        next_offset_out       = next_offset_ptr;
        next_error_pause      = (|next_errors) || next_illegal_err;
    end

    // outputs, all registered
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata             <= 8'h00;
            scsi_ack_allowed      <= 1'b0;
            scsi_dma_run          <= 1'b0;
            host_dma_run          <= 1'b0;
            path_to_scsi          <= 1'b0;
            sequencer_free_access <= 1'b1;
            hold_odd_byte         <= 1'b0;
            drain_active          <= 1'b0;
            accept_partial_quad   <= 1'b0;
            buffer_clear          <= 1'b0;
            byte_offset_pointer   <= DPC_OFFSET_RESET;
            error_pause           <= 1'b0;
        end
        else
        begin
            reg_rdata             <= next_rdata;
            scsi_ack_allowed      <= next_scsi_ack_allowed;
            scsi_dma_run          <= next_scsi_dma_run;
            host_dma_run          <= next_host_dma_run;
            path_to_scsi          <= next_path_to_scsi;
            sequencer_free_access <= next_free_access;
            hold_odd_byte         <= next_hold_odd_byte;
            drain_active          <= next_drain_active;
            accept_partial_quad   <= next_partial_quad;
            buffer_clear          <= next_buffer_clear;
            byte_offset_pointer   <= next_offset_out;
            error_pause           <= next_error_pause;
        end
    end
endmodule
`default_nettype wire

// File: dv/dpc_far_model.sv
// far side model: scsi bus, scsi dma, host stages and drain engine
`default_nettype none
module dpc_far_model (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic slow,
    input  wire logic scsi_ack_allowed,
    input  wire logic scsi_dma_run,
    input  wire logic host_dma_run,
    input  wire logic drain_active,
    output logic      scsi_bus_idle,
    output logic      scsi_dma_idle,
    output logic      host_dma_idle,
    output logic      drain_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0][2:0] cnt;
    logic [3:0]      busy;
    logic [2:0]      lat;
    assign busy = {drain_active, host_dma_run, scsi_dma_run, scsi_ack_allowed};
    assign lat  = slow ? 3'h5 : 3'h1;
    // a stage stops some cycles after its enable drops
    assign scsi_bus_idle = !busy[0] && cnt[0] >= lat;
    assign scsi_dma_idle = !busy[1] && cnt[1] >= lat;
    assign host_dma_idle = !busy[2] && cnt[2] >= lat;
    // drain ends some cycles after it starts
    assign drain_done = busy[3] && cnt[3] == lat;
    always_ff @(posedge clock or negedge reset_n)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!reset_n)
                cnt[i] <= 3'h0;
            else if (busy[i] != (i == 3))
                cnt[i] <= 3'h0;
            else if (cnt[i] != 3'h7)
                cnt[i] <= cnt[i] + 3'h1;
        end
    end
endmodule
`default_nettype wire

// File: dv/dpc_data_path_control_chk.sv
// port checks for the data path control block
`default_nettype none
module dpc_data_path_control_chk
    import dpc_pkg::*;
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       soft_chip_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] pci_status_bits,
    input wire logic [2:0] host_address_low_bits,
    input wire logic [6:0] buffer_status_in,
    input wire logic       sync_offset_nonzero,
    input wire logic       data_in_phase,
    input wire logic       wide_transfer,
    input wire logic       odd_byte_count,
    input wire logic       sequencer_writing,
    input wire logic       scsi_ack_allowed,
    input wire logic       scsi_dma_run,
    input wire logic       host_dma_run,
    input wire logic       path_to_scsi,
    input wire logic       hold_odd_byte,
    input wire logic       drain_active,
    input wire logic       accept_partial_quad,
    input wire logic       buffer_clear,
    input wire logic [2:0] byte_offset_pointer
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic wc;
    assign wc = reg_write && reg_addr == DPC_ADDR_CONTROL && !soft_chip_reset;
    a_clear_pulse: assert property (wc && reg_wdata[0] |=> buffer_clear)
        else $error("clear strobe gave no pulse");
    a_offset_load: assert property (wc && reg_wdata[0] |=> byte_offset_pointer == $past(host_address_low_bits))
        else $error("offset pointer not loaded");
    a_pci_summary: assert property (reg_read && reg_addr == DPC_ADDR_ERROR
        |=> reg_rdata[6] == |$past(pci_status_bits) && reg_rdata[7] == 1'h0 && reg_rdata[1:0] == 2'h0)
        else $error("error summary wrong");
    a_sync_force: assert property (sync_offset_nonzero && data_in_phase && !soft_chip_reset |=> scsi_ack_allowed)
        else $error("sync data-in not enabled");
    a_soft_clear: assert property (soft_chip_reset |=> !(scsi_dma_run || host_dma_run || drain_active || hold_odd_byte))
        else $error("soft reset left control set");
    a_hold_qual: assert property (hold_odd_byte |-> $past(wide_transfer && odd_byte_count))
        else $error("hold outside wide odd transfer");
    a_path_stable: assert property ($changed(path_to_scsi) |-> $past(!(scsi_dma_run || host_dma_run) || soft_chip_reset))
        else $error("direction changed while running");
    a_partial_quad: assert property (accept_partial_quad |-> $past(sequencer_writing))
        else $error("partial quad without sequencer");
    a_drain_ignore: assert property (wc && reg_wdata[1] && buffer_status_in[0] && !drain_active |=> !drain_active)
        else $error("drain started on empty buffer");
    c_clear: cover property (wc && reg_wdata[0]);
    c_drain: cover property (drain_active);
    c_path: cover property ($changed(path_to_scsi));
endmodule
`default_nettype wire

// File: dv/tb_data_path_control_and_error_status.sv
// testbench for the data path control and error status block
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_data_path_control_and_error_status
    import dpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] pci_status_bits;
    logic [2:0] host_address_low_bits, byte_offset_pointer;
    logic [6:0] buffer_status_in;
    logic soft_chip_reset, reg_write, reg_read, memory_parity_fail, memory_parity_check_enable, datapath_parity_fail,
        datapath_parity_check_enable, control_store_parity_fail, control_store_parity_disable, illegal_fetch,
        clear_parity_errors, wide_transfer, odd_byte_count, sync_offset_nonzero, data_in_phase, scsi_bus_idle,
        scsi_dma_idle, host_dma_idle, scsi_count_zero, scsi_phase_change, auto_drain_disable, drain_done,
        sequencer_writing, slow, scsi_ack_allowed, scsi_dma_run, host_dma_run, path_to_scsi, sequencer_free_access,
        hold_odd_byte, drain_active, accept_partial_quad, buffer_clear, error_pause;
    int err_count = 0;
    int samples_checked = 0;
    dpc_data_path_control dut (.clock, .reset_n, .soft_chip_reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .pci_status_bits, .memory_parity_fail, .memory_parity_check_enable, .datapath_parity_fail,
        .datapath_parity_check_enable, .control_store_parity_fail, .control_store_parity_disable, .illegal_fetch,
        .clear_parity_errors, .wide_transfer, .odd_byte_count, .sync_offset_nonzero, .data_in_phase, .scsi_bus_idle,
        .scsi_dma_idle, .host_dma_idle, .scsi_count_zero, .scsi_phase_change, .auto_drain_disable, .drain_done,
        .sequencer_writing, .host_address_low_bits, .buffer_status_in, .scsi_ack_allowed, .scsi_dma_run,
        .host_dma_run, .path_to_scsi, .sequencer_free_access, .hold_odd_byte, .drain_active, .accept_partial_quad,
        .buffer_clear, .byte_offset_pointer, .error_pause);
    dpc_far_model far (.clock, .reset_n, .slow, .scsi_ack_allowed, .scsi_dma_run, .host_dma_run, .drain_active,
        .scsi_bus_idle, .scsi_dma_idle, .host_dma_idle, .drain_done);
    always #25 clock = ~clock;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        @(negedge clock);
        `CHK(reg_rdata, e)
    endtask
    task automatic idle_wait();
        repeat (12) @(negedge clock);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_clear();
        @(posedge clock);
        host_address_low_bits <= 3'h5;
        wr(DPC_ADDR_CONTROL, 8'h01);
        `CHK({buffer_clear, byte_offset_pointer}, 4'hD)
        rd(DPC_ADDR_CONTROL, 8'h00);
        rd(8'h55, 8'h00);
        $display("test clear done");
    endtask
    task automatic t_enables();
        wr(DPC_ADDR_CONTROL, 8'h38);
        `CHK({scsi_ack_allowed, scsi_dma_run, host_dma_run}, 3'h7)
        wr(DPC_ADDR_CONTROL, 8'h00);
        rd(DPC_ADDR_CONTROL, 8'h38);
        idle_wait();
        rd(DPC_ADDR_CONTROL, 8'h00);
        $display("test enables done");
    endtask
    task automatic t_dir();
        wr(DPC_ADDR_CONTROL, 8'h18);
        @(negedge clock);
        `CHK(sequencer_free_access, 1'h0)
        wr(DPC_ADDR_CONTROL, 8'h1C);
        `CHK(path_to_scsi, 1'h0)
        wr(DPC_ADDR_CONTROL, 8'h04);
        idle_wait();
        `CHK({path_to_scsi, sequencer_free_access}, 2'h3)
        $display("test direction done");
    endtask
    task automatic t_drain();
        wr(DPC_ADDR_CONTROL, 8'h06);
        rd(DPC_ADDR_CONTROL, 8'h04);
        @(posedge clock);
        sequencer_writing <= 1'h1;
        wr(DPC_ADDR_CONTROL, 8'h06);
        `CHK({drain_active, accept_partial_quad}, 2'h3)
        idle_wait();
        sequencer_writing <= 1'h0;
        wr(DPC_ADDR_CONTROL, 8'h00);
        buffer_status_in <= 7'h01;
        wr(DPC_ADDR_CONTROL, 8'h02);
        rd(DPC_ADDR_CONTROL, 8'h00);
        buffer_status_in <= 7'h00;
        wr(DPC_ADDR_CONTROL, 8'h02);
        rd(DPC_ADDR_CONTROL, 8'h02);
        idle_wait();
        rd(DPC_ADDR_CONTROL, 8'h00);
        {auto_drain_disable, scsi_phase_change} <= 2'h3;
        @(posedge clock);
        {auto_drain_disable, scsi_phase_change} <= 2'h0;
        idle_wait();
        `CHK(drain_active, 1'h0)
        @(posedge clock);
        scsi_count_zero <= 1'h1;
        @(posedge clock);
        scsi_count_zero <= 1'h0;
        @(negedge clock);
        `CHK(drain_active, 1'h1)
        idle_wait();
        $display("test drain done");
    endtask
    task automatic t_misc();
        {wide_transfer, odd_byte_count, sync_offset_nonzero, data_in_phase} <= 4'hF;
        wr(DPC_ADDR_CONTROL, 8'h40);
        `CHK({hold_odd_byte, scsi_ack_allowed}, 2'h3)
        {odd_byte_count, data_in_phase} <= 2'h0;
        @(posedge clock);
        @(negedge clock);
        `CHK({hold_odd_byte, scsi_ack_allowed}, 2'h0)
        $display("test hold and sync done");
    endtask
    task automatic t_errors();
        {memory_parity_fail, datapath_parity_fail, control_store_parity_fail} <= 3'h7;
        control_store_parity_disable <= 1'h1;
        @(posedge clock);
        {memory_parity_fail, datapath_parity_fail, control_store_parity_fail} <= 3'h0;
        rd(DPC_ADDR_ERROR, 8'h00);
        {memory_parity_check_enable, datapath_parity_check_enable, control_store_parity_disable} <= 3'h6;
        {memory_parity_fail, datapath_parity_fail, control_store_parity_fail, illegal_fetch} <= 4'hF;
        pci_status_bits <= 6'h20;
        @(posedge clock);
        {memory_parity_fail, datapath_parity_fail, control_store_parity_fail, illegal_fetch} <= 4'h0;
        rd(DPC_ADDR_ERROR, 8'h7C);
        `CHK(error_pause, 1'h1)
        clear_parity_errors <= 1'h1;
        @(posedge clock);
        clear_parity_errors <= 1'h0;
        rd(DPC_ADDR_ERROR, 8'h44);
        soft_chip_reset <= 1'h1;
        @(posedge clock);
        soft_chip_reset <= 1'h0;
        rd(DPC_ADDR_ERROR, 8'h40);
        rd(DPC_ADDR_CONTROL, 8'h00);
        pci_status_bits <= 6'h00;
        rd(DPC_ADDR_ERROR, 8'h00);
        `CHK(error_pause, 1'h0)
        $display("test errors done");
    endtask
    initial
    begin
        {soft_chip_reset, reg_write, reg_read, memory_parity_fail, memory_parity_check_enable, datapath_parity_fail,
            datapath_parity_check_enable, control_store_parity_fail, control_store_parity_disable, illegal_fetch,
            clear_parity_errors, wide_transfer, odd_byte_count, sync_offset_nonzero, data_in_phase, scsi_count_zero,
            scsi_phase_change, auto_drain_disable, sequencer_writing} = '0;
        {reg_addr, reg_wdata, pci_status_bits, host_address_low_bits, buffer_status_in} = '0;
        slow = 1'h1;
        repeat (16) @(posedge clock);
        reset_n <= 1'h1;
        rd(DPC_ADDR_CONTROL, DPC_CONTROL_RESET);
        t_clear();
        t_enables();
        t_dir();
        t_drain();
        t_misc();
        t_errors();
        close_out();
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        err_count++;
        close_out();
    end
endmodule
bind dpc_data_path_control dpc_data_path_control_chk chk (.clock, .reset_n, .soft_chip_reset, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pci_status_bits, .host_address_low_bits, .buffer_status_in,
    .sync_offset_nonzero, .data_in_phase, .wide_transfer, .odd_byte_count, .sequencer_writing, .scsi_ack_allowed,
    .scsi_dma_run, .host_dma_run, .path_to_scsi, .hold_odd_byte, .drain_active, .accept_partial_quad,
    .buffer_clear, .byte_offset_pointer);
`default_nettype wire
